// *** rtl/cimc_ctrl.v ***
// contact input decoding, preset and regulation mode control, fault relay
`timescale 1ns/1ps
`include "cimc_regs.vh"
module cimc_ctrl #(
   parameter DEBOUNCE_CYC = `CIMC_DEBOUNCE_CYC,
   parameter TICK_CYC = `CIMC_TICK_CYC,
   parameter CNT_W = 21,
   parameter TICK_W = 18
) (
   // clock and reset
   input wire ref_clk,
   input wire rst_n,
   // user contacts, pin level, closed pulls low
   input wire raise_contact,
   input wire lower_contact,
   input wire droop_disable_contact,
   input wire excitation_inhibit_contact,
   input wire reactive_ctrl_inhibit_contact,
   input wire preset_select_bit0,
   input wire preset_select_bit1,
   input wire regulator_restart_contact,
   // front panel buttons, pressed pulls low
   input wire panel_select_btn,
   input wire panel_raise_btn,
   input wire panel_lower_btn,
   input wire panel_enter_btn,
   // configuration from front panel or software
   input wire mode_wr,
   input wire [`CIMC_MODE_W-1:0] mode_wdata,
   input wire pol_wr,
   input wire [2:0] pol_wdata,
   input wire rate_wr,
   input wire [`CIMC_RATE_W-1:0] rate_wdata,
   input wire [`CIMC_OFS_W-1:0] contact_limit,
   input wire keep_offset_option,
   input wire [`CIMC_OFS_W-1:0] stored_offset,
   input wire setpoint_wr,
   input wire [`CIMC_OFS_W-1:0] setpoint_wdata,
   input wire aux_enable,
   input wire [`CIMC_OFS_W-1:0] aux_offset,
   // regulator status
   input wire standby,
   input wire protective_shutdown,
   // mode and preset status
   output reg [`CIMC_MODE_W-1:0] selected_mode_q,
   output reg [`CIMC_MODE_W-1:0] active_mode_q,
   output reg [1:0] active_preset_q,
   output reg [2:0] polarity_q,
   output reg [`CIMC_RATE_W-1:0] ramp_rate_q,
   // set point
   output wire [`CIMC_OFS_W-1:0] contact_offset,
   output reg [`CIMC_OFS_W-1:0] setpoint_q,
   output reg [`CIMC_OFS_W-1:0] save_offset_q,
   output reg save_offset_pulse_q,
   // excitation, droop, relay
   output reg droop_enable_q,
   output reg excitation_enable_q,
   output reg soft_start_pulse_q,
   output reg alarm_clear_pulse_q,
   output reg restart_pulse_q,
   output reg relay_no_closed_q,
   output reg relay_nc_closed_q,
   output reg [3:0] panel_press_q
);
   // debounce of every contact and button
   wire [`CIMC_NUM_CH-1:0] raw_in = {panel_enter_btn, panel_lower_btn, panel_raise_btn,
      panel_select_btn, regulator_restart_contact, preset_select_bit1,
      preset_select_bit0, reactive_ctrl_inhibit_contact, excitation_inhibit_contact,
      droop_disable_contact, lower_contact, raise_contact};
   wire [`CIMC_NUM_CH-1:0] lvl;
   wire [`CIMC_NUM_CH-1:0] chg;

   genvar i;
   generate
      for (i = 0; i < `CIMC_NUM_CH; i = i + 1) begin : g_deb
         cimc_debounce #(
            .CYCLES(DEBOUNCE_CYC),
            .CNT_W(CNT_W)
         ) u_deb (
            .ref_clk(ref_clk),
            .rst_n(rst_n),
            .raw(raw_in[i]),
            .stable_q(lvl[i]),
            .changed_q(chg[i])
         );
      end
   endgenerate

   // closed means the debounced pin reads low for fixed-polarity contacts
   wire raise_on = ~lvl[`CIMC_CH_RAISE];
   wire lower_on = ~lvl[`CIMC_CH_LOWER];
   wire ps0_on = ~lvl[`CIMC_CH_PS0];
   wire ps1_on = ~lvl[`CIMC_CH_PS1];
   // polarity bit 0 = active low, 1 = active high
   wire droop_off_on = lvl[`CIMC_CH_DROOP] ~^ polarity_q[`CIMC_POL_DROOP];
   wire exc_inh_on = lvl[`CIMC_CH_EXC] ~^ polarity_q[`CIMC_POL_EXC];
   wire rctl_inh_on = lvl[`CIMC_CH_RCTL] ~^ polarity_q[`CIMC_POL_RCTL];

   // restart on every debounced toggle, either edge
   wire restart = chg[`CIMC_CH_RST];
   reg init_q;

   // mode classes
   wire volt_mode = (active_mode_q == `CIMC_MODE_1PH) || (active_mode_q == `CIMC_MODE_3PH);
   wire fcr_mode = (active_mode_q == `CIMC_MODE_FCR);
   wire mode_ok = (mode_wdata <= `CIMC_MODE_PF);

   // selected mode, one of five
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         selected_mode_q <= `CIMC_MODE_RESET;
      end else if (restart) begin
         selected_mode_q <= `CIMC_MODE_RESET;
      end else if (mode_wr && mode_ok) begin
         selected_mode_q <= mode_wdata;
      end
   end

   // effective mode after the reactive inhibit contact
   reg [`CIMC_MODE_W-1:0] active_mode_d;
   always @* begin
      active_mode_d = selected_mode_q;
      case (selected_mode_q)
         `CIMC_MODE_VAR, `CIMC_MODE_PF: begin
            if (rctl_inh_on) begin
               active_mode_d = `CIMC_MODE_3PH;
            end
         end
         default: begin
            active_mode_d = selected_mode_q;
         end
      endcase
   end

   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         active_mode_q <= `CIMC_MODE_RESET;
      end else if (restart) begin
         active_mode_q <= `CIMC_MODE_RESET;
      end else begin
         active_mode_q <= active_mode_d;
      end
   end

   // preset latch; a change outside standby waits until standby is entered
   wire [1:0] preset_req = {ps1_on, ps0_on};
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         active_preset_q <= 2'h0;
      end else if (standby && (preset_req != active_preset_q)) begin
         active_preset_q <= preset_req;
      end
   end

   // polarity is global, so it is only writable while preset 0 is active
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         polarity_q <= `CIMC_POL_RESET;
      end else if (pol_wr && (active_preset_q == 2'h0)) begin
         polarity_q <= pol_wdata;
      end
   end

   // ramp rate in 0.1 %/s steps, out of range writes are ignored
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ramp_rate_q <= `CIMC_RATE_RESET;
      end else if (rate_wr && (rate_wdata >= `CIMC_RATE_MIN) &&
                   (rate_wdata <= `CIMC_RATE_MAX)) begin
         ramp_rate_q <= rate_wdata;
      end
   end

   // millisecond tick: rate lsb of 0.1 %/s equals one offset lsb per ms
   reg [TICK_W-1:0] tick_cnt_q;
   reg tick_q;
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         tick_cnt_q <= {TICK_W{1'b0}};
         tick_q <= 1'b0;
      end else if (tick_cnt_q == TICK_CYC[TICK_W-1:0] - 1'b1) begin
         tick_cnt_q <= {TICK_W{1'b0}};
         tick_q <= 1'b1;
      end else begin
         tick_cnt_q <= tick_cnt_q + 1'b1;
         tick_q <= 1'b0;
      end
   end

   // limits: symmetric contact limit, or 0..full scale in field current mode
   wire [`CIMC_OFS_W-1:0] neg_limit = (~contact_limit) + 1'b1;
   wire [`CIMC_OFS_W-1:0] lo_lim = fcr_mode ? {`CIMC_OFS_W{1'b0}} : neg_limit;
   wire [`CIMC_OFS_W-1:0] hi_lim = fcr_mode ? `CIMC_FULL_SCALE : contact_limit;

   // restored offset after power-up or restart; kept only in voltage modes
   wire restore_keep = keep_offset_option && volt_mode;
   wire [`CIMC_OFS_W-1:0] restore_val = restore_keep ? stored_offset : {`CIMC_OFS_W{1'b0}};
   reg mode_chg_q;
   wire ramp_load = init_q || mode_chg_q;

   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         init_q <= 1'b1;
         mode_chg_q <= 1'b0;
      end else begin
         init_q <= restart;
         // offsets mean nothing across a change into or out of field current mode, so start again
         mode_chg_q <= (active_mode_d != active_mode_q) && (fcr_mode ||
            (active_mode_d == `CIMC_MODE_FCR));
      end
   end

   cimc_ramp #(
      .W(`CIMC_OFS_W),
      .RW(`CIMC_RATE_W)
   ) u_ramp (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .tick(tick_q),
      .up(raise_on),
      .down(lower_on),
      .rate(ramp_rate_q),
      .lo(lo_lim),
      .hi(hi_lim),
      .load(ramp_load),
      .load_val(fcr_mode ? {`CIMC_OFS_W{1'b0}} : restore_val),
      .acc_q(contact_offset)
   );

   // save request on every raise/lower change in a voltage mode with the keep offset option set
   reg save_pend_q;
   wire rl_change = chg[`CIMC_CH_RAISE] || chg[`CIMC_CH_LOWER];
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         save_pend_q <= 1'b0;
         save_offset_q <= {`CIMC_OFS_W{1'b0}};
         save_offset_pulse_q <= 1'b0;
      end else begin
         save_pend_q <= rl_change && keep_offset_option && volt_mode;
         save_offset_pulse_q <= save_pend_q;
         // capture one cycle late so the last ramp step is included
         if (save_pend_q) begin
            save_offset_q <= contact_offset;
         end
      end
   end

   // set point base from panel or software, summed with contact and aux
   reg [`CIMC_OFS_W-1:0] base_q;
   wire [`CIMC_OFS_W-1:0] aux_term = aux_enable ? aux_offset : {`CIMC_OFS_W{1'b0}};
   wire [`CIMC_OFS_W-1:0] sp_sum = base_q + contact_offset + aux_term;
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         base_q <= {`CIMC_OFS_W{1'b0}};
         setpoint_q <= {`CIMC_OFS_W{1'b0}};
      end else begin
         if (restart) begin
            base_q <= {`CIMC_OFS_W{1'b0}};
         end else if (setpoint_wr) begin
            base_q <= setpoint_wdata;
         end
         if (fcr_mode && sp_sum[`CIMC_OFS_W-1]) begin
            // a negative field current reference is held at zero
            setpoint_q <= {`CIMC_OFS_W{1'b0}};
         end else begin
            setpoint_q <= sp_sum;
         end
      end
   end

   // droop only meaningful in the four load-sharing modes
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         droop_enable_q <= 1'b0;
      end else begin
         droop_enable_q <= ~droop_off_on && ~fcr_mode;
      end
   end

   // excitation inhibit: remove field drive, soft start and clear on release
   reg exc_inh_q;
   wire exc_release = exc_inh_q && ~exc_inh_on;
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         exc_inh_q <= 1'b0;
         excitation_enable_q <= 1'b0;
         soft_start_pulse_q <= 1'b0;
         alarm_clear_pulse_q <= 1'b0;
         restart_pulse_q <= 1'b0;
      end else begin
         exc_inh_q <= exc_inh_on;
         excitation_enable_q <= ~exc_inh_on && ~relay_no_closed_q;
         soft_start_pulse_q <= exc_release || restart;
         alarm_clear_pulse_q <= exc_release || restart;
         restart_pulse_q <= restart;
      end
   end

   // fault relay: latched on shutdown, a new shutdown wins over a clear
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         relay_no_closed_q <= 1'b0;
         relay_nc_closed_q <= 1'b1;
      end else if (protective_shutdown) begin
         relay_no_closed_q <= 1'b1;
         relay_nc_closed_q <= 1'b0;
      end else if (exc_release || restart) begin
         relay_no_closed_q <= 1'b0;
         relay_nc_closed_q <= 1'b1;
      end
   end

   // front panel presses: select, raise, lower, enter on press edge
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         panel_press_q <= 4'h0;
      end else begin
         panel_press_q <= chg[`CIMC_NUM_CH-1:`CIMC_CH_BTN] &
            ~lvl[`CIMC_NUM_CH-1:`CIMC_CH_BTN];
      end
   end
endmodule // cimc_ctrl

// *** rtl/cimc_regs.vh ***
// constants for the contact input and mode control block
`ifndef CIMC_REGS_VH
`define CIMC_REGS_VH

// clock and timing
`define CIMC_CLK_MHZ 200
`define CIMC_DEBOUNCE_US 10000
`define CIMC_DEBOUNCE_CYC (`CIMC_DEBOUNCE_US * `CIMC_CLK_MHZ)
`define CIMC_TICK_US 1000
`define CIMC_TICK_CYC (`CIMC_TICK_US * `CIMC_CLK_MHZ)

// regulation modes
`define CIMC_MODE_W 3
`define CIMC_MODE_1PH 3'h0
`define CIMC_MODE_3PH 3'h1
`define CIMC_MODE_FCR 3'h2
`define CIMC_MODE_VAR 3'h3
`define CIMC_MODE_PF 3'h4
`define CIMC_MODE_RESET 3'h1

// offset scaling: 1 lsb = 0.0001 % of full scale, 24 bit signed
`define CIMC_OFS_W 24
`define CIMC_FULL_SCALE 24'h0F_4240
`define CIMC_RATE_W 8
`define CIMC_RATE_MIN 8'h01
`define CIMC_RATE_MAX 8'h96
`define CIMC_RATE_RESET 8'h0A

// contact channel indices
`define CIMC_CH_RAISE 0
`define CIMC_CH_LOWER 1
`define CIMC_CH_DROOP 2
`define CIMC_CH_EXC 3
`define CIMC_CH_RCTL 4
`define CIMC_CH_PS0 5
`define CIMC_CH_PS1 6
`define CIMC_CH_RST 7
`define CIMC_CH_BTN 8
`define CIMC_NUM_CH 12

// polarity field positions, reset value: all active low
`define CIMC_POL_DROOP 0
`define CIMC_POL_EXC 1
`define CIMC_POL_RCTL 2
`define CIMC_POL_RESET 3'h0

`endif

// *** rtl/cimc_debounce.v ***
// two-flop synchroniser and stability debouncer for one contact
`timescale 1ns/1ps
module cimc_debounce #(
   parameter CYCLES = 2000000,
   parameter CNT_W = 21
) (
   // clock and reset
   input wire ref_clk,
   input wire rst_n,
   // contact
   input wire raw,
   output reg stable_q,
   output reg changed_q
);
   reg sync1_q;
   reg sync2_q;
   reg [CNT_W-1:0] cnt_q;

   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_q <= 1'b1;
         sync2_q <= 1'b1;
         cnt_q <= {CNT_W{1'b0}};
         stable_q <= 1'b1;
         changed_q <= 1'b0;
      end else begin
         sync1_q <= raw;
         sync2_q <= sync1_q;
         changed_q <= 1'b0;
         // any bounce restarts the count
         if (sync2_q == stable_q) begin
            cnt_q <= {CNT_W{1'b0}};
         end else if (cnt_q == CYCLES[CNT_W-1:0] - 1'b1) begin
            cnt_q <= {CNT_W{1'b0}};
            stable_q <= sync2_q;
            changed_q <= 1'b1;
         end else begin
            cnt_q <= cnt_q + 1'b1;
         end
      end
   end
endmodule // cimc_debounce

// *** rtl/cimc_ramp.v ***
// clamped set point offset accumulator stepped once per tick
`timescale 1ns/1ps
module cimc_ramp #(
   parameter W = 24,
   parameter RW = 8
) (
   // clock and reset
   input wire ref_clk,
   input wire rst_n,
   // control
   input wire tick,
   input wire up,
   input wire down,
   input wire [RW-1:0] rate,
   input wire signed [W-1:0] lo,
   input wire signed [W-1:0] hi,
   input wire load,
   input wire signed [W-1:0] load_val,
   // result
   output reg signed [W-1:0] acc_q
);
   wire signed [W:0] step = {{(W-RW+1){1'b0}}, rate};
   wire signed [W:0] acc_x = {acc_q[W-1], acc_q};
   wire signed [W:0] sum = up ? acc_x + step : acc_x - step;
   reg signed [W-1:0] acc_d;

   always @* begin
      acc_d = acc_q;
      if (load) begin
         acc_d = load_val;
      end else if (tick && (up ^ down)) begin
         // saturate at the limit instead of wrapping
         // a bare concatenation is unsigned and would turn the compare unsigned
         if (sum > $signed({hi[W-1], hi})) begin
            acc_d = hi;
         end else if (sum < $signed({lo[W-1], lo})) begin
            acc_d = lo;
         end else begin
            acc_d = sum[W-1:0];
         end
      end
   end

   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         acc_q <= {W{1'b0}};
      end else begin
         acc_q <= acc_d;
      end
   end
endmodule // cimc_ramp

// *** tb/cimc_ctrl_props.sv ***
// concurrent checks on the contact input and mode control ports
`timescale 1ns/1ps
`include "cimc_regs.vh"
module cimc_ctrl_props (
   // clock and reset
   input ref_clk,
   input rst_n,
   // configuration strobes and status
   input mode_wr,
   input [2:0] mode_wdata,
   input rate_wr,
   input [7:0] rate_wdata,
   input pol_wr,
   input standby,
   input protective_shutdown,
   // observed outputs
   input [2:0] selected_mode_q,
   input [2:0] active_mode_q,
   input [1:0] active_preset_q,
   input [2:0] polarity_q,
   input [7:0] ramp_rate_q,
   input excitation_enable_q,
   input restart_pulse_q,
   input relay_no_closed_q,
   input relay_nc_closed_q
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   property p_relay_set;
      protective_shutdown |=> relay_no_closed_q && !relay_nc_closed_q;
   endproperty
   a_relay_set: assert property (p_relay_set) else $error("relay not energised");
   property p_exc_off;
      relay_no_closed_q [*2] |-> !excitation_enable_q;
   endproperty
   a_exc_off: assert property (p_exc_off) else $error("excitation on after trip");
   property p_mode_wr;
      mode_wr && mode_wdata <= 3'h4 |=> selected_mode_q == $past(mode_wdata);
   endproperty
   a_mode_wr: assert property (p_mode_wr) else $error("mode not taken");
   property p_mode_ref;
      mode_wr && mode_wdata > 3'h4 && !restart_pulse_q |=> $stable(selected_mode_q);
   endproperty
   a_mode_ref: assert property (p_mode_ref) else $error("bad mode taken");
   // reactive and power factor modes only follow a matching selection
   property p_react;
      active_mode_q >= `CIMC_MODE_VAR |-> $past(selected_mode_q) == active_mode_q;
   endproperty
   a_react: assert property (p_react) else $error("reactive mode not selected");
   property p_rate;
      rate_wr && rate_wdata >= `CIMC_RATE_MIN && rate_wdata <= `CIMC_RATE_MAX
         |=> ramp_rate_q == $past(rate_wdata);
   endproperty
   a_rate: assert property (p_rate) else $error("ramp rate not taken");
   property p_pol_lock;
      pol_wr && active_preset_q != 2'h0 |=> $stable(polarity_q);
   endproperty
   a_pol_lock: assert property (p_pol_lock) else $error("polarity written off preset");
   property p_preset_hold;
      !standby && !restart_pulse_q |=> $stable(active_preset_q);
   endproperty
   a_preset_hold: assert property (p_preset_hold) else $error("preset moved");
   property p_restart_pulse;
      restart_pulse_q |=> !restart_pulse_q;
   endproperty
   a_restart_pulse: assert property (p_restart_pulse) else $error("restart pulse long");
   c_trip: cover property (protective_shutdown ##1 relay_no_closed_q);
   c_pol_lock: cover property (pol_wr && active_preset_q != 2'h0);
   c_restart: cover property (restart_pulse_q);
endmodule // cimc_ctrl_props

bind cimc_ctrl cimc_ctrl_props u_cimc_ctrl_props (.*);

// *** tb/cimc_contacts.sv ***
// dry contact and panel button model, a closed contact pulls its pin low
`timescale 1ns/1ps
module cimc_contacts (
   // clock
   input ref_clk,
   // requested state, 1 = closed
   input [11:0] close,
   input chatter,
   // pin levels
   output reg [11:0] pin
);
   reg [11:0] last_q;
   reg [2:0] bounce_q;
   initial begin
      pin = 12'hFFF;
      last_q = 12'h000;
      bounce_q = 3'h0;
   end
   always @(posedge ref_clk) begin
      if (close != last_q && chatter) bounce_q <= 3'h4;
      else if (bounce_q != 3'h0) bounce_q <= bounce_q - 3'h1;
      last_q <= close;
      // bounce stays shorter than the debounce interval so it must be filtered
      if (bounce_q[0]) pin <= ~pin;
      else pin <= ~close;
   end
endmodule // cimc_contacts

// *** tb/testbench.sv ***
// self-checking bench for the contact input and mode control block
`timescale 1ns/1ps
`include "cimc_regs.vh"
module testbench;
   reg ref_clk = 0, rst_n = 0, chatter = 0, mode_wr = 0, pol_wr = 0, rate_wr = 0;
   reg setpoint_wr = 0, aux_enable = 0, standby = 0, protective_shutdown = 0;
   reg keep_offset_option = 1;
   reg [11:0] close = 0;
   reg [2:0] mode_wdata = 0, pol_wdata = 0;
   reg [7:0] rate_wdata = 0;
   reg [23:0] contact_limit = 24'h00_0003, setpoint_wdata = 0, aux_offset = 0;
   reg [23:0] stored_offset = 24'h00_0005;
   wire [11:0] pin;
   wire [2:0] selected_mode_q, active_mode_q, polarity_q;
   wire [1:0] active_preset_q;
   wire [7:0] ramp_rate_q;
   wire [23:0] contact_offset, setpoint_q, save_offset_q;
   wire save_offset_pulse_q, droop_enable_q, excitation_enable_q, soft_start_pulse_q;
   wire alarm_clear_pulse_q, restart_pulse_q, relay_no_closed_q, relay_nc_closed_q;
   wire [3:0] panel_press_q;
   integer fail_count = 0, compares = 0, saves = 0, softs = 0, clrs = 0, rsts = 0, i, b0, b1;
   reg [3:0] press_seen = 0;

   cimc_contacts u_cimc_contacts (.ref_clk, .close, .chatter, .pin);
   cimc_ctrl #(.DEBOUNCE_CYC(8), .TICK_CYC(16)) u_cimc_ctrl (.ref_clk, .rst_n,
      .raise_contact(pin[0]), .lower_contact(pin[1]), .droop_disable_contact(pin[2]),
      .excitation_inhibit_contact(pin[3]), .reactive_ctrl_inhibit_contact(pin[4]),
      .preset_select_bit0(pin[5]), .preset_select_bit1(pin[6]),
      .regulator_restart_contact(pin[7]), .panel_select_btn(pin[8]),
      .panel_raise_btn(pin[9]), .panel_lower_btn(pin[10]), .panel_enter_btn(pin[11]),
      .mode_wr, .mode_wdata, .pol_wr, .pol_wdata, .rate_wr, .rate_wdata, .contact_limit,
      .keep_offset_option, .stored_offset, .setpoint_wr, .setpoint_wdata,
      .aux_enable, .aux_offset, .standby, .protective_shutdown, .selected_mode_q,
      .active_mode_q, .active_preset_q, .polarity_q, .ramp_rate_q, .contact_offset,
      .setpoint_q, .save_offset_q, .save_offset_pulse_q, .droop_enable_q,
      .excitation_enable_q, .soft_start_pulse_q, .alarm_clear_pulse_q, .restart_pulse_q,
      .relay_no_closed_q, .relay_nc_closed_q, .panel_press_q);

   initial begin
      forever #2.5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      saves <= saves + save_offset_pulse_q;
      softs <= softs + soft_start_pulse_q;
      clrs <= clrs + alarm_clear_pulse_q;
      rsts <= rsts + restart_pulse_q;
      press_seen <= press_seen | panel_press_q;
   end

   task chk(input [23:0] got, input [23:0] exp);
      compares = compares + 1;
      if (got !== exp) begin
         fail_count = fail_count + 1;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task step(input integer n);
      repeat (n) @(posedge ref_clk);
      @(negedge ref_clk);
   endtask
   task set_mode(input [2:0] m);
      mode_wr = 1;
      mode_wdata = m;
      step(1);
      mode_wr = 0;
      step(2);
   endtask
   task set_pol(input [2:0] p);
      pol_wr = 1;
      pol_wdata = p;
      step(1);
      pol_wr = 0;
      step(2);
   endtask
   // debounce of 8 plus synchroniser and output registers
   task settle;
      step(16);
   endtask

   task t_reset;
      chk(active_mode_q, `CIMC_MODE_RESET);
      chk(polarity_q, 3'h0);
      chk(ramp_rate_q, `CIMC_RATE_RESET);
      chk({relay_no_closed_q, relay_nc_closed_q}, 2'b01);
      chk(contact_offset, 24'h00_0005);
      $display("test reset done");
   endtask
   task t_mode;
      for (i = 0; i < 5; i = i + 1) begin
         set_mode(i[2:0]);
         chk(selected_mode_q, i[2:0]);
         chk(active_mode_q, i[2:0]);
      end
      set_mode(3'h5);
      chk(selected_mode_q, `CIMC_MODE_PF);
      close[4] = 1;
      settle;
      chk(active_mode_q, `CIMC_MODE_3PH);
      close[4] = 0;
      settle;
      chk(active_mode_q, `CIMC_MODE_PF);
      $display("test mode done");
   endtask
   task t_droop;
      chk(droop_enable_q, 1'b1);
      close[2] = 1;
      settle;
      chk(droop_enable_q, 1'b0);
      set_mode(`CIMC_MODE_3PH);
      close[2] = 0;
      settle;
      chk(droop_enable_q, 1'b1);
      $display("test droop done");
   endtask
   task t_exc;
      chk(excitation_enable_q, 1'b1);
      close[3] = 1;
      settle;
      chk(excitation_enable_q, 1'b0);
      protective_shutdown = 1;
      step(1);
      protective_shutdown = 0;
      chk({relay_no_closed_q, relay_nc_closed_q}, 2'b10);
      b0 = softs;
      b1 = clrs;
      close[3] = 0;
      settle;
      chk({relay_no_closed_q, relay_nc_closed_q, excitation_enable_q}, 3'b011);
      chk(softs - b0, 1);
      chk(clrs - b1, 1);
      // trip with the inhibit open: the relay alone drops excitation until restart
      protective_shutdown = 1;
      step(1);
      protective_shutdown = 0;
      step(1);
      chk({relay_no_closed_q, relay_nc_closed_q, excitation_enable_q}, 3'b100);
      $display("test excitation done");
   endtask
   task t_preset;
      close[6:5] = 2'b11;
      settle;
      chk(active_preset_q, 2'h0);
      standby = 1;
      step(2);
      chk(active_preset_q, 2'h3);
      set_pol(3'h7);
      chk(polarity_q, 3'h0);
      close[6:5] = 2'b01;
      settle;
      chk(active_preset_q, 2'h1);
      close[6:5] = 2'b00;
      settle;
      set_pol(3'h1);
      chk({polarity_q, droop_enable_q}, 4'h2);
      set_pol(3'h0);
      standby = 0;
      $display("test preset done");
   endtask
   task t_ramp;
      rate_wr = 1;
      rate_wdata = 8'h97;
      step(1);
      rate_wdata = `CIMC_RATE_MIN;
      step(1);
      rate_wr = 0;
      setpoint_wr = 1;
      setpoint_wdata = 24'h00_0064;
      step(1);
      setpoint_wr = 0;
      aux_enable = 1;
      aux_offset = 24'h00_0002;
      b0 = saves;
      close[0] = 1;
      step(120);
      chk(contact_offset, contact_limit);
      chk(setpoint_q, 24'h00_0069);
      close[0] = 0;
      settle;
      chk(save_offset_q, 24'h00_0003);
      chk(saves - b0, 2);
      close[1] = 1;
      step(150);
      chk(contact_offset, 24'hFF_FFFD);
      // field current mode: floor at zero, contact limit no longer applies
      set_mode(`CIMC_MODE_FCR);
      step(40);
      chk(contact_offset, 24'h00_0000);
      chk(setpoint_q, 24'h00_0066);
      close[1:0] = 2'b01;
      step(120);
      chk(contact_offset > contact_limit, 1'b1);
      close[0] = 0;
      set_mode(`CIMC_MODE_3PH);
      aux_enable = 0;
      settle;
      $display("test ramp done");
   endtask
   task t_restart;
      set_mode(`CIMC_MODE_1PH);
      chatter = 1;
      b0 = rsts;
      close[7] = 1;
      close[11:8] = 4'hF;
      // chatter stretches the debounce by the bounce span
      settle;
      step(4);
      chk(rsts - b0, 1);
      chk(selected_mode_q, `CIMC_MODE_RESET);
      chk({relay_no_closed_q, relay_nc_closed_q}, 2'b01);
      chk(contact_offset, 24'h00_0005);
      chk(press_seen, 4'hF);
      close[11:8] = 4'h0;
      chatter = 0;
      keep_offset_option = 0;
      close[7] = 0;
      settle;
      chk(rsts - b0, 2);
      chk(contact_offset, 24'h00_0000);
      $display("test restart done");
   endtask

   task close_out;
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   initial begin
      repeat (5) @(posedge ref_clk);
      @(negedge ref_clk);
      rst_n = 1;
      step(2);
      t_reset;
      t_mode;
      t_droop;
      t_exc;
      t_preset;
      t_ramp;
      t_restart;
      close_out;
   end
   initial begin
      #50000;
      fail_count = fail_count + 1;
      close_out;
   end
endmodule // testbench
